// ===== design/ccm_defs.svh
// Address map, field positions, reset values and sizes of the capture/compare mode block.
// Assumes inclusion by bare name from design files that also import ccm_pkg.
`ifndef CCM_DEFS_SVH
`define CCM_DEFS_SVH

// Register word indexes of the six mode registers (byte address is four times the index)
`define CCM_MODE_IDX0 10'h0da
`define CCM_MODE_IDX_END 10'h0e0
// Byte addresses of the control, status, mask and value registers
`define CCM_CTRL_ADDR 12'h380
`define CCM_STAT_ADDR 12'h384
`define CCM_MASK_ADDR 12'h388
`define CCM_VAL_BASE 12'h390
`define CCM_VAL_END 12'h3a8

// Module count and the module that doubles as watchdog
`define CCM_NUM_MOD 6
`define CCM_WDG_MOD 3'h5

// Control register fields
`define CCM_WDG_BIT 6
`define CCM_WIDTH_LSB 1
`define CCM_WIDTH_MSB 2

// Reset values and the base pulse-width size
`define CCM_CTRL_RST 8'h40
`define CCM_MODE_RST 8'h00
`define CCM_STAT_RST 6'h00
`define CCM_MASK_RST 6'h00
`define CCM_VAL_RST 16'h0000
`define CCM_BASE_WIDTH 5'h08

`endif

// ===== design/ccm_pkg.sv
// Types shared by the capture/compare mode block and its channel module.
// Assumes nothing of its surroundings.
package ccm_pkg;

    // Mode register layout, bit 7 down to bit 0
    typedef struct packed {
        logic sixteen_bit_modulation_select;
        logic comparator_enable;
        logic rising_capture_enable;
        logic falling_capture_enable;
        logic match_flag_enable;
        logic toggle_enable;
        logic pulse_modulation_enable;
        logic flag_interrupt_enable;
    } ccm_mode_t;

    // Register selected by an APB address
    typedef enum logic [5:0] {
        CCM_SEL_NONE = 6'b000001,
        CCM_SEL_MODE = 6'b000010,
        CCM_SEL_CTRL = 6'b000100,
        CCM_SEL_STAT = 6'b001000,
        CCM_SEL_MASK = 6'b010000,
        CCM_SEL_VAL = 6'b100000
    } ccm_sel_t;

    typedef struct packed {
        ccm_sel_t sel;
        logic [2:0] idx;
    } ccm_dec_t;

    // Events reported by one channel
    typedef struct packed {
        logic capture;
        logic event_hit;
    } ccm_evt_t;

    // Pin drive of one channel
    typedef struct packed {
        logic level;
        logic oe_n;
    } ccm_pin_t;

endpackage

// ===== design/ccm_channel.sv
// One capture/compare channel: edge capture, match, toggle, pulse-width and frequency output.
// Assumes a shared 16-bit counter and a pin input synchronous to clk.
`timescale 1ns/100ps
`include "ccm_defs.svh"

module ccm_channel
    import ccm_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input ccm_mode_t mode,
    input wire logic [15:0] counter,
    input wire logic [15:0] compare,
    input wire logic [1:0] pwm_width,
    input wire logic pin_in,
    output ccm_evt_t evt,
    output ccm_pin_t pin
);

    logic pin_prev_q;
    logic [7:0] freq_mark_q;
    logic rise;
    logic fall;
    logic match16;
    logic match8;
    logic freq_mode;
    logic pwm_level;
    logic [15:0] width_mask;

    // Mask that keeps the low 8 to 11 counter bits
    function automatic logic [15:0] ccm_low_mask(input logic [1:0] w);
        logic [4:0] bits;
        bits = 5'(`CCM_BASE_WIDTH + {3'h0, w});
        ccm_low_mask = 16'((17'h00001 << bits) - 17'h00001);
    endfunction

    // Edge and match detection
    assign rise = pin_in & ~pin_prev_q;
    assign fall = ~pin_in & pin_prev_q;
    assign match16 = mode.comparator_enable && (counter == compare);
    assign match8 = mode.comparator_enable && (counter[7:0] == freq_mark_q);
    assign freq_mode = mode.toggle_enable & mode.pulse_modulation_enable;
    assign width_mask = ccm_low_mask(pwm_width);

    // Pulse-width level: high from the compare point to the end of the period
    always_comb begin
        if (mode.sixteen_bit_modulation_select) begin
            pwm_level = counter >= compare;
        end else begin
            pwm_level = (counter & width_mask) >= (compare & width_mask);
        end
    end

    // Previous pin sample for edge detection
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_prev_q <= 1'b0;
        end else begin
            pin_prev_q <= pin_in;
        end
    end

    // Capture and match events, one cycle pulses
    always_ff @(posedge clk) begin
        if (rst) begin
            evt <= '0;
        end else begin
            evt.capture <= (mode.rising_capture_enable & rise)
                | (mode.falling_capture_enable & fall);
            evt.event_hit <= (mode.rising_capture_enable & rise)
                | (mode.falling_capture_enable & fall)
                | (mode.match_flag_enable & match16);
        end
    end

    // Next toggle point in frequency output, advanced by the high compare byte
    always_ff @(posedge clk) begin
        if (rst) begin
            freq_mark_q <= 8'h00;
        end else if (!freq_mode) begin
            freq_mark_q <= compare[7:0];
        end else if (match8) begin
            freq_mark_q <= 8'(freq_mark_q + compare[15:8]);
        end
    end

    // Pin drive
    always_ff @(posedge clk) begin
        if (rst) begin
            pin <= '{level: 1'b0, oe_n: 1'b1};
        end else begin
            pin.oe_n <= ~(mode.toggle_enable | mode.pulse_modulation_enable);
            if (freq_mode) begin
                if (match8) begin
                    pin.level <= ~pin.level;
                end
            end else if (mode.pulse_modulation_enable) begin
                pin.level <= mode.comparator_enable & pwm_level;
            end else if (mode.toggle_enable && match16) begin
                pin.level <= ~pin.level;
            end
        end
    end

endmodule // ccm_channel

// ===== design/ccm_top.sv
// APB register front end and six capture/compare channels with event flags and interrupt.
// Assumes an APB master on clk, a shared 16-bit counter input and pins sampled on clk.
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/100ps
`include "ccm_defs.svh"

module ccm_top
    import ccm_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] counter_value,
    input wire logic [5:0] module_io_pin_i,
    output logic [5:0] module_io_pin_o,
    output logic [5:0] module_io_pin_oe_n,
    output logic irq,
    output logic watchdog_active
);

    ccm_mode_t mode_q [`CCM_NUM_MOD];
    logic [15:0] value_q [`CCM_NUM_MOD];
    logic [7:0] counter_mode_register_q;
    logic [5:0] module_event_flag_q;
    logic [5:0] int_mask_q;
    logic [5:0] flag_int_en;
    logic [5:0] flag_set;
    logic [5:0] flag_clr;
    logic [5:0] capture_hit;
    ccm_evt_t evt [`CCM_NUM_MOD];
    ccm_pin_t pin [`CCM_NUM_MOD];
    ccm_dec_t dec;
    logic access;
    logic wr_en;
    logic rd_en;
    logic [31:0] rd_data;

    // Map a byte address onto a register and module index
    function automatic ccm_dec_t ccm_decode(input logic [11:0] a);
        ccm_dec_t d;
        d.sel = CCM_SEL_NONE;
        d.idx = 3'h0;
        if (a[1:0] != 2'b00) begin
            d.sel = CCM_SEL_NONE;
        end else if (a[11:2] >= `CCM_MODE_IDX0 && a[11:2] < `CCM_MODE_IDX_END) begin
            d.sel = CCM_SEL_MODE;
            d.idx = 3'(a[11:2] - `CCM_MODE_IDX0);
        end else if (a == `CCM_CTRL_ADDR) begin
            d.sel = CCM_SEL_CTRL;
        end else if (a == `CCM_STAT_ADDR) begin
            d.sel = CCM_SEL_STAT;
        end else if (a == `CCM_MASK_ADDR) begin
            d.sel = CCM_SEL_MASK;
        end else if (a >= `CCM_VAL_BASE && a < `CCM_VAL_END) begin
            d.sel = CCM_SEL_VAL;
            d.idx = 3'((a - `CCM_VAL_BASE) >> 2);
        end
        return d;
    endfunction

    // Bus phase decoding; a write lands only on the edge that samples pready
    assign dec = ccm_decode(paddr);
    assign access = psel & penable;
    assign wr_en = access & pready & pwrite;
    assign rd_en = access & ~pready & ~pwrite;

    // Channels
    for (genvar n = 0; n < `CCM_NUM_MOD; n++) begin : g_chan
        ccm_channel u_chan (
            .clk(clk),
            .rst(rst),
            .mode(mode_q[n]),
            .counter(counter_value),
            .compare(value_q[n]),
            .pwm_width(counter_mode_register_q[`CCM_WIDTH_MSB:`CCM_WIDTH_LSB]),
            .pin_in(module_io_pin_i[n]),
            .evt(evt[n]),
            .pin(pin[n])
        );
        assign capture_hit[n] = evt[n].capture;
        assign flag_set[n] = evt[n].event_hit;
        assign flag_int_en[n] = mode_q[n].flag_interrupt_enable;
        assign module_io_pin_o[n] = pin[n].level;
        assign module_io_pin_oe_n[n] = pin[n].oe_n;
    end

    // APB handshake: one wait state, then pready for one cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= access & ~pready;
            pslverr <= access & ~pready & (dec.sel == CCM_SEL_NONE);
        end
    end

    // Read data multiplexer
    always_comb begin
        rd_data = 32'h0000_0000;
        case (dec.sel)
            CCM_SEL_MODE: rd_data = {24'h000000, mode_q[dec.idx]};
            CCM_SEL_CTRL: rd_data = {24'h000000, counter_mode_register_q};
            CCM_SEL_STAT: rd_data = {26'h0000000, module_event_flag_q};
            CCM_SEL_MASK: rd_data = {26'h0000000, int_mask_q};
            CCM_SEL_VAL: rd_data = {16'h0000, value_q[dec.idx]};
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // Read data register, loaded with pready
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata <= rd_data;
        end
    end

    // Counter mode register with the watchdog bit set out of reset
    always_ff @(posedge clk) begin
        if (rst) begin
            counter_mode_register_q <= `CCM_CTRL_RST;
        end else if (wr_en && dec.sel == CCM_SEL_CTRL) begin
            counter_mode_register_q <= pwdata[7:0];
        end
    end

    // Mode registers; module five is locked while it is the watchdog
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < `CCM_NUM_MOD; i++) begin
                mode_q[i] <= `CCM_MODE_RST;
            end
        end else if (wr_en && dec.sel == CCM_SEL_MODE) begin
            if (!(dec.idx == `CCM_WDG_MOD && counter_mode_register_q[`CCM_WDG_BIT])) begin
                mode_q[dec.idx] <= pwdata[7:0];
            end
        end
    end

    // Value registers; a capture wins over a software write to the same module
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < `CCM_NUM_MOD; i++) begin
                value_q[i] <= `CCM_VAL_RST;
            end
        end else begin
            for (int i = 0; i < `CCM_NUM_MOD; i++) begin
                if (capture_hit[i]) begin
                    value_q[i] <= counter_value;
                end else if (wr_en && dec.sel == CCM_SEL_VAL && dec.idx == 3'(i)) begin
                    value_q[i] <= pwdata[15:0];
                end
            end
        end
    end

    // Event flags: write one to clear, a new event in the same cycle wins
    assign flag_clr = (wr_en && dec.sel == CCM_SEL_STAT) ? pwdata[5:0] : 6'h00;

    always_ff @(posedge clk) begin
        if (rst) begin
            module_event_flag_q <= `CCM_STAT_RST;
        end else begin
            module_event_flag_q <= (module_event_flag_q & ~flag_clr) | flag_set;
        end
    end

    // Interrupt mask
    always_ff @(posedge clk) begin
        if (rst) begin
            int_mask_q <= `CCM_MASK_RST;
        end else if (wr_en && dec.sel == CCM_SEL_MASK) begin
            int_mask_q <= pwdata[5:0];
        end
    end

    // Interrupt level and watchdog indication
    always_ff @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
            watchdog_active <= 1'b1;
        end else begin
            irq <= |(module_event_flag_q & int_mask_q & flag_int_en);
            watchdog_active <= counter_mode_register_q[`CCM_WDG_BIT];
        end
    end

endmodule // ccm_top

// ===== bench/ccm_top_asserts.sv
// Checker for the capture/compare mode block, bound to its top ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module ccm_top_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [5:0] module_io_pin_oe_n,
    input wire logic irq,
    input wire logic watchdog_active
);
    logic wr_done, ctrl_wr, mode_wr;
    // Completed writes, split by target
    assign wr_done = psel && penable && pready && pwrite;
    assign ctrl_wr = wr_done && paddr == 12'h380;
    assign mode_wr = wr_done && paddr >= 12'h368 && paddr < 12'h380;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence apb_wait;
        psel && penable && !pready;
    endsequence
    access_wait_a: assert property (apb_setup ##1 apb_wait |=> pready)
        else $error("access not answered after one wait");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_cause_a: assert property (pready |-> psel && penable && $past(psel && penable))
        else $error("pready without access");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    unmapped_err_a: assert property (apb_wait and paddr >= 12'h3a8 |=> pslverr)
        else $error("unmapped access not refused");
    wdg_reset_a: assert property ($past(rst) |-> watchdog_active && !irq)
        else $error("reset state wrong");
    wdg_ctrl_only_a: assert property ($changed(watchdog_active) |->
        $past(ctrl_wr) || $past(ctrl_wr, 2))
        else $error("watchdog bit moved without write");
    lock_silent_a: assert property (wr_done && paddr == 12'h37c && watchdog_active
        |-> !pslverr)
        else $error("locked write flagged");
    oe_mode_a: assert property ($changed(module_io_pin_oe_n) |->
        $past(mode_wr) || $past(mode_wr, 2))
        else $error("pin enable moved without mode write");
    read_upper_a: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
        else $error("upper read bits set");
endmodule // ccm_top_asserts

bind ccm_top ccm_top_asserts chk (.clk, .rst, .psel, .penable, .pwrite, .paddr, .prdata,
    .pready, .pslverr, .module_io_pin_oe_n, .irq, .watchdog_active);

// ===== bench/ccm_pin_model.sv
// Far side of the six module pins: external drivers that yield to the block.
// Assumes the bench calls set_level from its clocked sequence.
`timescale 1ns/100ps
module ccm_pin_model (
    input wire logic clk,
    input wire logic [5:0] pin_o,
    input wire logic [5:0] pin_oe_n,
    output logic [5:0] pin_i
);
    logic [5:0] ext_q = 6'h00;
    // Wire level: the block wins while its enable is low
    assign pin_i = (pin_o & ~pin_oe_n) | (ext_q & pin_oe_n);
    // External edge on one pin, launched right after a rising edge
    task automatic set_level(input int n, input logic v);
        @(posedge clk);
        ext_q[n] <= v;
    endtask
endmodule // ccm_pin_model

// ===== bench/tb_top.sv
// Self-checking bench for the capture/compare mode block over APB.
// Assumes the design, its checker bind and the pin model are compiled first.
`timescale 1ns/100ps
`include "ccm_defs.svh"
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq, err, p;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [15:0] counter_value = 16'hffff;
    logic [5:0] pin_i, pin_o, pin_oe_n;
    logic watchdog_active;
    int errors = 0, checks_done = 0;
    // 50 MHz clock
    always #10 clk = ~clk;
    ccm_top uut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .counter_value, .module_io_pin_i(pin_i), .module_io_pin_o(pin_o),
        .module_io_pin_oe_n(pin_oe_n), .irq, .watchdog_active);
    ccm_pin_model pm (.clk, .pin_o, .pin_oe_n, .pin_i);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            errors++;
            print_verdict();
        end
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string what);
        apb(1'b0, a, 32'h0);
        check(rdat, e, what);
    endtask
    function automatic logic [11:0] ma(input int n);
        return {`CCM_MODE_IDX0, 2'b00} + 12'(4 * n);
    endfunction
    // One-cycle counter value, then idle
    task automatic pulse(input logic [15:0] c);
        @(posedge clk);
        counter_value <= c;
        @(posedge clk);
        counter_value <= 16'hffff;
        tick(4);
    endtask
    // Pin edge on module 1 with the counter at c; check value, flag and irq
    task automatic cap(input logic v, input logic [15:0] c, input logic [15:0] ev,
        input logic fl, input logic iq);
        @(posedge clk);
        counter_value <= c;
        pm.set_level(1, v);
        tick(4);
        check(irq, iq, "irq");
        rd(`CCM_VAL_BASE + 12'h4, ev, "capture");
        rd(`CCM_STAT_ADDR, {fl, 1'b0}, "flag");
        wr(`CCM_STAT_ADDR, 32'h3f);
    endtask
    // Main sequence
    initial begin
        tick(20);
        rst <= 1'b0;
        tick(1);
        rd(`CCM_CTRL_ADDR, `CCM_CTRL_RST, "ctrl");
        for (int n = 0; n < 6; n++) begin
            rd(ma(n), 32'h0, "mode reset");
            wr(ma(n), 32'h5a + n);
            check(err, 1'b0, "mode err");
            rd(ma(n), n == 5 ? 32'h0 : 32'h5a + n, "mode");
            wr(ma(n), 32'h0);
        end
        wr(`CCM_CTRL_ADDR, 32'h0);
        tick(2);
        check(watchdog_active, 1'b0, "wdg");
        wr(ma(5), 32'h81);
        rd(ma(5), 32'h81, "mode5");
        wr(`CCM_CTRL_ADDR, 32'h40);
        wr(ma(5), 32'h0);
        rd(ma(5), 32'h81, "mode5 lock");
        wr(`CCM_CTRL_ADDR, 32'h0);
        apb(1'b0, 12'hffc, 32'h0);
        check(err, 1'b1, "unmapped");
        wr(`CCM_MASK_ADDR, 32'h3f);
        wr(`CCM_STAT_ADDR, 32'h3f);
        wr(ma(1), 32'h21);
        cap(1'b1, 16'h1234, 16'h1234, 1'b1, 1'b1);
        cap(1'b0, 16'h2222, 16'h1234, 1'b0, 1'b0);
        wr(ma(1), 32'h10);
        cap(1'b1, 16'h3333, 16'h1234, 1'b0, 1'b0);
        cap(1'b0, 16'h4321, 16'h4321, 1'b1, 1'b0);
        wr(`CCM_VAL_BASE, 32'h50);
        wr(ma(0), 32'h09);
        pulse(16'h0050);
        rd(`CCM_STAT_ADDR, 32'h0, "no compare");
        wr(ma(0), 32'h49);
        pulse(16'h0050);
        check(irq, 1'b1, "match irq");
        wr(`CCM_MASK_ADDR, 32'h0);
        tick(2);
        check(irq, 1'b0, "masked");
        wr(`CCM_MASK_ADDR, 32'h3f);
        rd(`CCM_STAT_ADDR, 32'h1, "match");
        wr(`CCM_STAT_ADDR, 32'h1);
        tick(2);
        check(irq, 1'b0, "cleared");
        wr(`CCM_VAL_BASE + 12'h8, 32'h100);
        wr(ma(2), 32'h44);
        tick(2);
        check(pin_oe_n[2], 1'b0, "drive");
        p = pin_o[2];
        for (int i = 0; i < 2; i++) begin
            pulse(16'h0100);
            check(pin_o[2], 1'(p ^ ~i[0]), "toggle");
        end
        wr(`CCM_VAL_BASE + 12'hc, 32'h8080);
        for (int i = 0; i < 4; i++) begin
            wr(ma(3), i < 2 ? 32'hc2 : 32'h42);
            @(posedge clk);
            counter_value <= i[0] ? 16'h0090 : 16'h9000;
            tick(3);
            check(pin_o[3], i[0] ^ (i < 2), "pwm");
        end
        // Width field at 3: an 11-bit compare sees 0x700 above 0x080, 8 bits would not
        wr(`CCM_CTRL_ADDR, 32'h6);
        @(posedge clk);
        counter_value <= 16'h0700;
        tick(3);
        check(pin_o[3], 1'b1, "pwm 11");
        wr(`CCM_CTRL_ADDR, 32'h0);
        tick(2);
        check(pin_o[3], 1'b0, "pwm 8");
        wr(`CCM_VAL_BASE + 12'h10, 32'h1005);
        wr(ma(4), 32'h46);
        tick(2);
        p = pin_o[4];
        pulse(16'h0005);
        check(pin_o[4], 1'(~p), "freq 1");
        pulse(16'h0015);
        check(pin_o[4], p, "freq 2");
        // Second reset in mid-run: the watchdog lock comes back with it
        tick(1);
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        tick(1);
        check(watchdog_active, 1'b1, "wdg reset");
        rd(`CCM_CTRL_ADDR, `CCM_CTRL_RST, "ctrl reset");
        rd(ma(4), 32'h0, "mode4 reset");
        wr(ma(5), 32'h81);
        rd(ma(5), 32'h0, "mode5 relock");
        print_verdict();
    end
endmodule // tb_top
